// ==== pll_seq_defs.vh ====
`ifndef PLL_SEQ_DEFS_VH
`define PLL_SEQ_DEFS_VH
// ----------------------------------------
// Register addresses and layouts
// ----------------------------------------
`define ADDR_PREDIV 8'hA9
`define ADDR_CONTROL 8'hB3
`define PREDIV_RESET 8'h01
`define CONTROL_RESET 8'h00
`define BIT_POWER 0
`define BIT_ENABLE 1
`define BIT_SRC 2
`define BIT_LOCK 4
`define BIT_RSVD 3
`define SPARE_MSB 7
`define SPARE_LSB 5
`define PREDIV_MSB 4
`define PREDIV_ZERO_DIV 6'h20
`define OSC_CHANNELS 2
`define OSC_CH_INT 0
`define OSC_CH_EXT 1
// ----------------------------------------
// Lock timing
// ----------------------------------------
`define LOCK_TIME_NS 20000
`define CLK_PERIOD_NS 20
`define LOCK_CYCLES (`LOCK_TIME_NS / `CLK_PERIOD_NS)
`endif

// ==== ref_divider.v ====
`timescale 1ns/1ps
`include "pll_seq_defs.vh"
// Divides the selected reference clock-enable by the pre-divide field.
module ref_divider (
    input wire sysClk,
    input wire rstSync,
    input wire refTick,
    input wire [4:0] divField,
    output reg divTick
);
    reg [5:0] count;
    wire [5:0] divisor;
    assign divisor = (divField == 5'h00) ? `PREDIV_ZERO_DIV : {1'b0, divField};

    // Count reference ticks, pulse once per divisor ticks
    always @(posedge sysClk or negedge rstSync) begin
        if (!rstSync) begin
            count <= 6'h00;
            divTick <= 1'b0;
        end else begin
            divTick <= 1'b0;
            if (refTick) begin
                if (count + 6'h01 >= divisor) begin
                    count <= 6'h00;
                    divTick <= 1'b1;
                end else begin
                    count <= count + 6'h01;
                end
            end
        end
    end
endmodule

// ==== pll_power_enable_sequencer.v ====
`timescale 1ns/1ps
`include "pll_seq_defs.vh"
// Contract
// - bias power bit one enables generator
// - enable bit one releases loop reset; the logic releases it only while the power bit is also one
// - lock flag rises once loop locks
// - enable and power clearable in one write
// - pre-divide field zero means 32
// - source select zero internal, one external
// - output equals reference times N over M; the logic only divides the selected reference by the pre-divide field
module pll_power_enable_sequencer #(
    parameter LOCK_WAIT = `LOCK_CYCLES
) (
    input wire sys_clk,
    input wire rst_n,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    input wire intOscTick,
    input wire extOscTick,
    output reg [7:0] regRdData,
    output reg biasPowerOn,
    output reg loopRun,
    output reg lockFlagOut,
    output reg refDivTick
);
    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    reg rstMeta;
    reg rstSync;
    // Async assert, synchronous release; every other flop
    // resets from this copy, so release never lands mid-edge
    // in one flop and a cycle later in another
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // ----------------------------------------
    // Oscillator tick synchronisers
    // ----------------------------------------
    // Raw oscillator levels, one per reference channel
    wire [`OSC_CHANNELS-1:0] oscIn;
    wire [`OSC_CHANNELS-1:0] oscEdge;
    // Channel order follows the source select encoding
    assign oscIn[`OSC_CH_INT] = intOscTick;
    assign oscIn[`OSC_CH_EXT] = extOscTick;

    // Ticks come from other domains, two stages first; the third
    // stage only feeds the edge detector, never the first stage
    genvar ch;
    generate
        for (ch = 0; ch < `OSC_CHANNELS; ch = ch + 1) begin : oscChan
            // Locals per channel keep one driver per flop
            reg oscMeta;
            reg oscSync;
            reg oscLast;
            always @(posedge sys_clk or negedge rstSync) begin
                if (!rstSync) begin
                    oscMeta <= 1'b0;
                    oscSync <= 1'b0;
                    oscLast <= 1'b0;
                end else begin
                    oscMeta <= oscIn[ch];
                    oscSync <= oscMeta;
                    oscLast <= oscSync;
                end
            end
            // One pulse per rising reference edge
            assign oscEdge[ch] = oscSync & ~oscLast;
        end
    endgenerate

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0] prediv;
    reg powerBit;
    reg enableBit;
    reg srcBit;
    // Lock flag is hardware owned; software cannot write it
    reg lockFlag;
    wire predivWrite;
    wire controlWrite;
    wire predivRead;
    wire controlRead;
    // Decode once so storage and read port agree on the address
    assign predivWrite = regWrite && (regAddr == `ADDR_PREDIV);
    assign controlWrite = regWrite && (regAddr == `ADDR_CONTROL);
    assign predivRead = regRead && (regAddr == `ADDR_PREDIV);
    assign controlRead = regRead && (regAddr == `ADDR_CONTROL);

    // Software writes; no side effects beyond storage. Other
    // addresses and the spare control bits are simply dropped.
    always @(posedge sys_clk or negedge rstSync) begin
        if (!rstSync) begin
            prediv <= `PREDIV_RESET;
            powerBit <= 1'b0;
            enableBit <= 1'b0;
            srcBit <= 1'b0;
        end else begin
            if (predivWrite) begin
                prediv <= regWrData;
            end
            if (controlWrite) begin
                powerBit <= regWrData[`BIT_POWER];
                enableBit <= regWrData[`BIT_ENABLE];
                srcBit <= regWrData[`BIT_SRC];
            end
        end
    end

    // ----------------------------------------
    // Reference path
    // ----------------------------------------
    wire refTick;
    wire divTick;
    // No glitch guard on a source change: one stray tick may land
    // zero internal, one external
    assign refTick = srcBit ? oscEdge[`OSC_CH_EXT] : oscEdge[`OSC_CH_INT];

    // Divider counts reference edges, not system clock cycles
    ref_divider divider (
        .sysClk(sys_clk),
        .rstSync(rstSync),
        .refTick(refTick),
        .divField(prediv[`PREDIV_MSB:0]),
        .divTick(divTick)
    );

    // ----------------------------------------
    // Control readback word
    // ----------------------------------------
    wire [7:0] controlWord;
    // Built bit by bit so each field sits at its named position
    // reserved bits read zero
    assign controlWord[`SPARE_MSB:`SPARE_LSB] = 3'b000;
    assign controlWord[`BIT_LOCK] = lockFlag;
    assign controlWord[`BIT_RSVD] = 1'b0;
    assign controlWord[`BIT_SRC] = srcBit;
    assign controlWord[`BIT_ENABLE] = enableBit;
    assign controlWord[`BIT_POWER] = powerBit;

    // ----------------------------------------
    // Lock model
    // ----------------------------------------
    reg [15:0] lockCount;
    wire loopActive;
    assign loopActive = powerBit & enableBit;

    // Lock is modelled as a settle time after release; the count
    // parks at its end so the flag holds while the loop runs
    always @(posedge sys_clk or negedge rstSync) begin
        if (!rstSync) begin
            lockCount <= 16'h0000;
            lockFlag <= 1'b0;
        end else if (!loopActive) begin
            lockCount <= 16'h0000;
            lockFlag <= 1'b0;
        end else if (lockCount >= LOCK_WAIT[15:0] - 16'h0001) begin
            lockFlag <= 1'b1;
        end else begin
            lockCount <= lockCount + 16'h0001;
        end
    end

    // ----------------------------------------
    // Outputs and read port
    // ----------------------------------------
    // Registered outputs; unused control bits read zero
    always @(posedge sys_clk or negedge rstSync) begin
        if (!rstSync) begin
            regRdData <= 8'h00;
            biasPowerOn <= 1'b0;
            loopRun <= 1'b0;
            lockFlagOut <= 1'b0;
            refDivTick <= 1'b0;
        end else begin
            // Status copies, one cycle behind the bits
            biasPowerOn <= powerBit;
            loopRun <= loopActive;
            lockFlagOut <= lockFlag;
            refDivTick <= divTick & loopActive;
            // Read data stands one cycle, then returns to zero
            if (predivRead) begin
                regRdData <= prediv;
            end else if (controlRead) begin
                regRdData <= controlWord;
            end else begin
                regRdData <= 8'h00;
            end
        end
    end
endmodule

// ==== pll_seq_chk.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module pll_seq_chk (
    input wire sys_clk,
    input wire rst_n,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regRdData,
    input wire biasPowerOn,
    input wire loopRun,
    input wire lockFlagOut,
    input wire refDivTick
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Control write, then its effect a few edges on
    sequence s_ctl; regWrite && regAddr == 8'hB3; endsequence
    sequence s_run; $rose(loopRun); endsequence
    property p_pwrOn; s_ctl ##0 regWrData[0] |-> ##[1:2] biasPowerOn; endproperty
    property p_pwrOff; s_ctl ##0 !regWrData[0] |-> ##[1:2] !biasPowerOn; endproperty
    property p_runOn; s_ctl ##0 regWrData[1:0] == 2'h3 |-> ##[1:3] loopRun; endproperty
    property p_runOff; s_ctl ##0 !regWrData[1] |-> ##[1:3] !loopRun; endproperty
    // Lock is a timer, so it never shows early
    property p_lockWait; s_run |-> !lockFlagOut [*8]; endproperty
    property p_lockClr; !loopRun |-> ##[0:1] !lockFlagOut; endproperty
    property p_ctlRd; $past(regRead && regAddr == 8'hB3) |->
        regRdData[7:5] == 3'h0 && !regRdData[3]; endproperty
    property p_tick; refDivTick |=> !refDivTick; endproperty
    a_pwrOn: assert property (p_pwrOn) else $error("bias late");
    a_pwrOff: assert property (p_pwrOff) else $error("bias stuck");
    a_runOn: assert property (p_runOn) else $error("run late");
    a_runOff: assert property (p_runOff) else $error("run stuck");
    a_lockWait: assert property (p_lockWait) else $error("early lock");
    a_lockClr: assert property (p_lockClr) else $error("lock stuck");
    a_ctlRd: assert property (p_ctlRd) else $error("spare bits");
    a_tick: assert property (p_tick) else $error("long tick");
endmodule
bind pll_power_enable_sequencer pll_seq_chk chk_u (.sys_clk, .rst_n,
    .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .biasPowerOn,
    .loopRun, .lockFlagOut, .refDivTick);

// ==== pll_power_enable_sequencer_tb.sv ====
`timescale 1ns/1ps
module pll_power_enable_sequencer_tb;
    logic sys_clk = 1'b0, rst_n = 1'b0, regWrite = 1'b0, regRead = 1'b0;
    logic intOscTick = 1'b0, extOscTick = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic biasPowerOn, loopRun, lockFlagOut, refDivTick;
    int failures = 0, n_compared = 0, cycles = 0, c;
    pll_power_enable_sequencer #(.LOCK_WAIT(10)) dut_u (.sys_clk, .rst_n,
        .regAddr, .regWrData, .regWrite, .regRead, .intOscTick, .extOscTick,
        .regRdData, .biasPowerOn, .loopRun, .lockFlagOut, .refDivTick);
    // Oscillator halves are multiples of 20 ns, so they move on falling edges
    always #10 sys_clk = ~sys_clk;
    always #60 intOscTick = ~intOscTick;
    always #80 extOscTick = ~extOscTick;
    // Hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            failures++;
            complete_run();
        end
    end
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    // Tick counts allow one tick of phase slack
    task automatic near(input int n, input int e);
        c = 0;
        repeat (n) @(negedge sys_clk) c += (refDivTick === 1'b1);
        n_compared++;
        if (c < e - 1 || c > e + 1) begin
            failures++;
            $display("[ERR] %0t ticks %0d want %0d", $time, c, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(negedge sys_clk);
        regWrite = 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge sys_clk);
        regRead = 1'b0;
        cmp(regRdData, e);
    endtask
    task automatic complete_run();
        $display("failures %0d compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_start();
        rdc(8'hA9, 8'h01);
        rdc(8'hB3, 8'h00);
        wr(8'hB3, 8'h00);
        wr(8'hB3, 8'h01);
        wr(8'hA9, 8'h02);
        cmp({5'h0, biasPowerOn, loopRun, lockFlagOut}, 8'h04);
        repeat (250) @(negedge sys_clk);
        wr(8'hB3, 8'h03);
        rdc(8'hB3, 8'h03);
        repeat (40) @(negedge sys_clk) if (lockFlagOut === 1'b1) break;
        wr(8'hB3, 8'hEB);
        rdc(8'hB3, 8'h13);
    endtask
    task automatic t_divide();
        near(480, 40);
        wr(8'hB3, 8'h07);
        wr(8'hB3, 8'h05);
        wr(8'hA9, 8'h00);
        wr(8'hB3, 8'h07);
        near(2560, 10);
    endtask
    task automatic t_off();
        wr(8'hB3, 8'h00);
        wr(8'h10, 8'hFF);
        cmp({5'h0, biasPowerOn, loopRun, lockFlagOut}, 8'h00);
        rdc(8'hB3, 8'h00);
        rdc(8'hA9, 8'h00);
        near(600, 0);
    endtask
    initial begin
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        t_start();
        t_divide();
        t_off();
        complete_run();
    end
endmodule
